// ===== common/cga_pkg.sv
// holds encodings, field positions and reset values of the general alu unit
// assumes a 32-bit core that hands over one decoded instruction word at a time
package cga_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int XLEN = 32;                    // data path width
   localparam int SHW  = 5;                     // shift amount width

   // ---------------------------------------------------------------
   // instruction field positions
   // ---------------------------------------------------------------
   localparam int OPC_HI   = 6;                 // major opcode
   localparam int OPC_LO   = 0;
   localparam int RD_HI    = 11;                // destination index
   localparam int RD_LO    = 7;
   localparam int F3_HI    = 14;                // function field, 3 bits
   localparam int F3_LO    = 12;
   localparam int IMM2_HI  = 24;                // clip width immediate
   localparam int IMM2_LO  = 20;
   localparam int F7_HI    = 31;                // function field, 7 bits
   localparam int F7_LO    = 25;
   localparam int IMM3_HI  = 29;                // shift amount immediate
   localparam int IMM3_LO  = 25;
   localparam int F2_RND   = 31;                // rounded variant
   localparam int F2_UNS   = 30;                // unsigned variant
   localparam int ACC_UNS  = 0;                 // funct7 bit: unsigned
   localparam int ACC_RND  = 1;                 // funct7 bit: rounded
   localparam int ACC_SUB  = 2;                 // funct7 bit: subtract

   // ---------------------------------------------------------------
   // major opcodes and 3-bit function codes
   // ---------------------------------------------------------------
   localparam logic [6:0] OPC_REG   = 7'h2b;    // register / width forms
   localparam logic [6:0] OPC_SHIMM = 7'h5b;    // immediate-shift forms
   localparam logic [2:0] F3_REG    = 3'h3;
   localparam logic [2:0] F3_ADDN   = 3'h2;
   localparam logic [2:0] F3_SUBN   = 3'h3;

   // ---------------------------------------------------------------
   // 7-bit function codes under OPC_REG
   // ---------------------------------------------------------------
   localparam logic [6:0] F7_ABS    = 7'h28;
   localparam logic [6:0] F7_SLE    = 7'h29;
   localparam logic [6:0] F7_SLEU   = 7'h2a;
   localparam logic [6:0] F7_MIN    = 7'h2b;
   localparam logic [6:0] F7_MINU   = 7'h2c;
   localparam logic [6:0] F7_MAX    = 7'h2d;
   localparam logic [6:0] F7_MAXU   = 7'h2e;
   localparam logic [6:0] F7_EXTHS  = 7'h30;
   localparam logic [6:0] F7_EXTHZ  = 7'h31;
   localparam logic [6:0] F7_EXTBS  = 7'h32;
   localparam logic [6:0] F7_EXTBZ  = 7'h33;
   localparam logic [6:0] F7_CLIP   = 7'h38;
   localparam logic [6:0] F7_CLIPU  = 7'h39;
   localparam logic [6:0] F7_CLIPR  = 7'h3a;
   localparam logic [6:0] F7_CLIPUR = 7'h3b;
   localparam logic [3:0] F7_ACC_HI = 4'h8;     // top four bits, 0x40..0x47

   // ---------------------------------------------------------------
   // constants and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] BOUND_MASK = 32'h7fffffff;
   localparam logic [31:0] RESULT_RST = 32'h00000000;
   localparam logic [4:0]  RD_RST     = 5'h00;

endpackage

// ===== common/cga_shift_if.sv
// carries one add/subtract, round and shift request and its answer
// assumes both ends sit in the same combinational cone of one clock
`timescale 1ns/10ps
interface cga_shift_if;
   logic [31:0] opa;        // minuend / first addend
   logic [31:0] opb;        // subtrahend / second addend
   logic [4:0]  shamt;      // shift distance
   logic        subtract;   // opa - opb instead of opa + opb
   logic        round_en;   // add half an lsb of the result first
   logic        arith;      // sign-filling shift
   logic [31:0] result;     // shifted value

   modport requester (output opa, opb, shamt, subtract, round_en, arith,
                      input  result);
   modport unit      (input  opa, opb, shamt, subtract, round_en, arith,
                      output result);
endinterface

// ===== src/cga_shift_round.sv
// add or subtract, optional rounding term, then right shift
// assumes operands are stable for the whole cycle; purely combinational
`timescale 1ns/10ps
module cga_shift_round (
   cga_shift_if.unit sr
);

   // ---------------------------------------------------------------
   // arithmetic core
   // ---------------------------------------------------------------
   logic [31:0] base;       // sum or difference, wraps at 32 bits
   logic [31:0] rnd_term;   // 2^(shamt-1) or zero
   logic [31:0] rounded;    // base plus rounding term
   logic        shamt_zero; // no shift, so no rounding either

   assign base       = sr.subtract ? sr.opa - sr.opb : sr.opa + sr.opb;
   assign shamt_zero = (sr.shamt == 5'h00);
   // zero shift must not add anything
   assign rnd_term   = (sr.round_en && !shamt_zero)
                       ? (32'h00000001 << (sr.shamt - 5'h01)) : 32'h00000000;
   assign rounded    = base + rnd_term;

   // ---------------------------------------------------------------
   // shifter: sign fill for signed forms, zero fill otherwise
   // ---------------------------------------------------------------
   assign sr.result  = sr.arith ? 32'($signed(rounded) >>> sr.shamt)
                                : (rounded >> sr.shamt);

endmodule

// ===== src/cga_general_alu.sv
// general alu unit: compare, min/max, extend, clip and add/sub with shift
// assumes decode hands one instruction with its operands per valid cycle
`timescale 1ns/10ps
module cga_general_alu (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        op_valid,
   input  wire logic [31:0] instr,
   input  wire logic [31:0] rs1_val,
   input  wire logic [31:0] rs2_val,
   input  wire logic [31:0] rd_val,
   output logic      [31:0] result_ff,
   output logic             result_valid_ff,
   output logic      [4:0]  rd_index_ff,
   output logic             acc_op_ff,
   output logic             unsupported_ff
);

   // ---------------------------------------------------------------
   // instruction fields
   // ---------------------------------------------------------------
   logic [6:0] opc;        // major opcode
   logic [2:0] f3;         // 3-bit function
   logic [6:0] f7;         // 7-bit function
   logic [4:0] clip_width_immediate;   // clip width
   logic [4:0] shift_amount_immediate; // shift distance
   logic       f2_rnd;     // rounded variant bit
   logic       f2_uns;     // unsigned variant bit

   assign opc = instr[cga_pkg::OPC_HI:cga_pkg::OPC_LO];
   assign f3  = instr[cga_pkg::F3_HI:cga_pkg::F3_LO];
   assign f7  = instr[cga_pkg::F7_HI:cga_pkg::F7_LO];
   assign clip_width_immediate   = instr[cga_pkg::IMM2_HI:cga_pkg::IMM2_LO];
   assign shift_amount_immediate = instr[cga_pkg::IMM3_HI:cga_pkg::IMM3_LO];
   assign f2_rnd = instr[cga_pkg::F2_RND];
   assign f2_uns = instr[cga_pkg::F2_UNS];

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   // two opcode spaces reach this unit; anything else in them,
   // such as the bit-manipulation codes, is flagged unsupported
   // rather than answered, so the core can raise its own trap
   // and the last result stays visible on result_ff
   logic reg_space;        // opcode 0101011 with funct 011
   logic imm_space;        // opcode 1011011, add or subtract

   assign reg_space = (opc == cga_pkg::OPC_REG)
                      && (f3 == cga_pkg::F3_REG);
   assign imm_space = (opc == cga_pkg::OPC_SHIMM)
                      && ((f3 == cga_pkg::F3_ADDN)
                          || (f3 == cga_pkg::F3_SUBN));

   logic absolute_value_op;
   logic set_less_equal_signed_op;
   logic set_less_equal_unsigned_op;
   logic minimum_signed_op;
   logic minimum_unsigned_op;
   logic maximum_signed_op;
   logic maximum_unsigned_op;
   logic halfword_sign_extend_op;
   logic halfword_zero_extend_op;
   logic byte_sign_extend_op;
   logic byte_zero_extend_op;
   logic saturate_signed_imm_op;
   logic saturate_unsigned_imm_op;
   logic saturate_signed_reg_op;
   logic saturate_unsigned_reg_op;
   logic acc_any_op;       // any of the eight accumulate forms
   logic shift_imm_any_op; // any of the eight immediate-shift forms

   // one compare per function code
   assign absolute_value_op          = reg_space && f7 == cga_pkg::F7_ABS;
   assign set_less_equal_signed_op   = reg_space && f7 == cga_pkg::F7_SLE;
   assign set_less_equal_unsigned_op = reg_space && f7 == cga_pkg::F7_SLEU;
   assign minimum_signed_op          = reg_space && f7 == cga_pkg::F7_MIN;
   assign minimum_unsigned_op        = reg_space && f7 == cga_pkg::F7_MINU;
   assign maximum_signed_op          = reg_space && f7 == cga_pkg::F7_MAX;
   assign maximum_unsigned_op        = reg_space && f7 == cga_pkg::F7_MAXU;
   assign halfword_sign_extend_op    = reg_space && f7 == cga_pkg::F7_EXTHS;
   assign halfword_zero_extend_op    = reg_space && f7 == cga_pkg::F7_EXTHZ;
   assign byte_sign_extend_op        = reg_space && f7 == cga_pkg::F7_EXTBS;
   assign byte_zero_extend_op        = reg_space && f7 == cga_pkg::F7_EXTBZ;
   assign saturate_signed_imm_op     = reg_space && f7 == cga_pkg::F7_CLIP;
   assign saturate_unsigned_imm_op   = reg_space && f7 == cga_pkg::F7_CLIPU;
   assign saturate_signed_reg_op     = reg_space && f7 == cga_pkg::F7_CLIPR;
   assign saturate_unsigned_reg_op   = reg_space && f7 == cga_pkg::F7_CLIPUR;
   // 0x40..0x47: low three bits pick unsigned, rounded, subtract
   assign acc_any_op       = reg_space && (f7[6:3] == cga_pkg::F7_ACC_HI);
   assign shift_imm_any_op = imm_space;

   // known_op gates the result register and the valid pulse;
   // keeping the list explicit means a new code added to the
   // decode above stays dormant until it is listed here too
   logic known_op;         // something this unit answers
   assign known_op = absolute_value_op | set_less_equal_signed_op
                   | set_less_equal_unsigned_op | minimum_signed_op
                   | minimum_unsigned_op | maximum_signed_op
                   | maximum_unsigned_op | halfword_sign_extend_op
                   | halfword_zero_extend_op | byte_sign_extend_op
                   | byte_zero_extend_op | saturate_signed_imm_op
                   | saturate_unsigned_imm_op | saturate_signed_reg_op
                   | saturate_unsigned_reg_op | acc_any_op
                   | shift_imm_any_op;

   // ---------------------------------------------------------------
   // comparators, shared by compare, min, max
   // ---------------------------------------------------------------
   // one signed and one unsigned less-than serve compare, min and
   // max alike; equality is separate so set-less-equal needs no
   // third magnitude comparator
   logic lt_s;             // rs1 < rs2, signed
   logic lt_u;             // rs1 < rs2, unsigned
   logic eq;               // rs1 == rs2

   assign lt_s = $signed(rs1_val) < $signed(rs2_val);
   assign lt_u = rs1_val < rs2_val;
   assign eq   = rs1_val == rs2_val;

   // ---------------------------------------------------------------
   // simple results
   // ---------------------------------------------------------------
   logic [31:0] abs_res;
   logic [31:0] sle_s_res;
   logic [31:0] sle_u_res;
   logic [31:0] min_s_res;
   logic [31:0] min_u_res;
   logic [31:0] max_s_res;
   logic [31:0] max_u_res;
   logic [31:0] exths_res;
   logic [31:0] exthz_res;
   logic [31:0] extbs_res;
   logic [31:0] extbz_res;

   // most negative value negates to itself, as in plain 32-bit wrap
   assign abs_res   = rs1_val[31] ? (32'h00000000 - rs1_val)
                                  : rs1_val;
   assign sle_s_res = {31'h00000000, lt_s | eq};
   assign sle_u_res = {31'h00000000, lt_u | eq};
   assign min_s_res = lt_s ? rs1_val : rs2_val;
   assign min_u_res = lt_u ? rs1_val : rs2_val;
   assign max_s_res = lt_s ? rs2_val : rs1_val;
   assign max_u_res = lt_u ? rs2_val : rs1_val;
   assign exths_res = {{16{rs1_val[15]}}, rs1_val[15:0]};
   assign exthz_res = {16'h0000, rs1_val[15:0]};
   assign extbs_res = {{24{rs1_val[7]}}, rs1_val[7:0]};
   assign extbz_res = {24'h000000, rs1_val[7:0]};

   // ---------------------------------------------------------------
   // clip bounds
   // ---------------------------------------------------------------
   // both clip flavours share one bound pair: immediate forms build
   // the bound from the width field, register forms from rs2 with
   // its sign bit cleared; the lower bound is the bitwise complement
   // of the upper, which equals -(upper + 1) in two's complement
   logic [31:0] imm_upper; // 2^(w-1)-1, or zero for width zero
   logic [31:0] reg_upper; // rs2 with sign bit cleared
   logic [31:0] upper;     // bound in use
   logic [31:0] lower;     // -(upper+1), which is the complement

   // width zero would shift by -1, so it is forced to zero instead
   assign imm_upper = (clip_width_immediate == 5'h00) ? 32'h00000000
                    : (32'h00000001 << (clip_width_immediate - 5'h01))
                      - 32'h00000001;
   assign reg_upper = rs2_val & cga_pkg::BOUND_MASK;
   assign upper     = (saturate_signed_reg_op | saturate_unsigned_reg_op)
                      ? reg_upper : imm_upper;
   assign lower     = ~upper;                   // gives -1 for width zero

   // all three tests compare as signed, so a negative rs1 floors at
   // zero in the unsigned clips instead of looking huge
   logic at_low;           // rs1 <= lower
   logic at_zero;          // rs1 <= 0, signed
   logic at_high;          // rs1 >= upper, signed

   assign at_low  = $signed(rs1_val) <= $signed(lower);
   assign at_zero = $signed(rs1_val) <= $signed(32'h00000000);
   assign at_high = $signed(rs1_val) >= $signed(upper);

   logic [31:0] clip_s_res;
   logic [31:0] clip_u_res;

   assign clip_s_res = at_low  ? lower
                     : at_high ? upper : rs1_val;
   assign clip_u_res = at_zero ? 32'h00000000
                     : at_high ? upper : rs1_val;

   // ---------------------------------------------------------------
   // add/sub with round and shift, in its own unit
   // ---------------------------------------------------------------
   // immediate and accumulate forms share one adder and shifter;
   // only the operand steering below differs between them
   // limitation: sums wrap at 32 bits before the shift, so no carry
   // bit reaches the top of a shifted result
   cga_shift_if sh_bus ();

   // accumulate forms take the destination as first operand
   assign sh_bus.opa      = acc_any_op ? rd_val : rs1_val;
   assign sh_bus.opb      = acc_any_op ? rs1_val : rs2_val;
   // register forms shift by the low five bits of rs2
   assign sh_bus.shamt    = acc_any_op ? rs2_val[4:0]
                                       : shift_amount_immediate;
   assign sh_bus.subtract = acc_any_op ? f7[cga_pkg::ACC_SUB]
                                       : (f3 == cga_pkg::F3_SUBN);
   assign sh_bus.round_en = acc_any_op ? f7[cga_pkg::ACC_RND]
                                       : f2_rnd;
   assign sh_bus.arith    = acc_any_op ? !f7[cga_pkg::ACC_UNS]
                                       : !f2_uns;

   cga_shift_round u_shift_round (
      .sr (sh_bus.unit)
   );

   // ---------------------------------------------------------------
   // result selection; decodes are mutually exclusive
   // ---------------------------------------------------------------
   logic [31:0] sel_res;

   assign sel_res =
        absolute_value_op          ? abs_res
      : set_less_equal_signed_op   ? sle_s_res
      : set_less_equal_unsigned_op ? sle_u_res
      : minimum_signed_op          ? min_s_res
      : minimum_unsigned_op        ? min_u_res
      : maximum_signed_op          ? max_s_res
      : maximum_unsigned_op        ? max_u_res
      : halfword_sign_extend_op    ? exths_res
      : halfword_zero_extend_op    ? exthz_res
      : byte_sign_extend_op        ? extbs_res
      : byte_zero_extend_op        ? extbz_res
      : saturate_signed_imm_op     ? clip_s_res
      : saturate_unsigned_imm_op   ? clip_u_res
      : saturate_signed_reg_op     ? clip_s_res
      : saturate_unsigned_reg_op   ? clip_u_res
      : (acc_any_op | shift_imm_any_op) ? sh_bus.result
      : cga_pkg::RESULT_RST;

   // ---------------------------------------------------------------
   // output stage: one register so every output is a flop
   // ---------------------------------------------------------------
   // registering the answer costs one cycle of latency but keeps
   // the long decode and adder paths away from the core's writeback
   logic [31:0] nxt_result;
   logic        nxt_valid;
   logic        nxt_acc;
   logic        nxt_unsup;

   // result only moves on a taken request; it holds otherwise
   assign nxt_result = (op_valid && known_op) ? sel_res : result_ff;
   assign nxt_valid  = op_valid && known_op;
   assign nxt_acc    = op_valid && acc_any_op;   // write back to rd
   assign nxt_unsup  = op_valid && !known_op;

   // data flops
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         result_ff   <= cga_pkg::RESULT_RST;
         rd_index_ff <= cga_pkg::RD_RST;
      end else begin
         result_ff   <= nxt_result;
         rd_index_ff <= op_valid ? instr[cga_pkg::RD_HI:cga_pkg::RD_LO]
                                 : rd_index_ff;
      end
   end

   // status flops, one-cycle pulses
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         result_valid_ff <= 1'b0;
         acc_op_ff       <= 1'b0;
         unsupported_ff  <= 1'b0;
      end else begin
         result_valid_ff <= nxt_valid;
         acc_op_ff       <= nxt_acc;
         unsupported_ff  <= nxt_unsup;
      end
   end

endmodule

// ===== sim/cga_general_alu_asserts.sv
// port checker for the general alu unit
// assumes it is bound onto cga_general_alu, one clock
`timescale 1ns/10ps
module cga_general_alu_asserts (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        op_valid,
   input wire logic [31:0] instr,
   input wire logic [31:0] rs1_val,
   input wire logic [31:0] rs2_val,
   input wire logic [31:0] rd_val,
   input wire logic [31:0] result_ff,
   input wire logic        result_valid_ff,
   input wire logic [4:0]  rd_index_ff,
   input wire logic        acc_op_ff,
   input wire logic        unsupported_ff
);
   // ---------------------------------------------------------------
   // reference values from the current request
   // ---------------------------------------------------------------
   wire        reg_op = instr[6:0] == 7'h2b && instr[14:12] == 3'h3;
   wire [6:0]  f7     = instr[31:25];
   wire [31:0] abs_w  = rs1_val[31] ? -rs1_val : rs1_val;
   wire [31:0] sle_w  = {31'h0, $signed(rs1_val) <= $signed(rs2_val)};
   wire [31:0] min_w  = $signed(rs1_val) < $signed(rs2_val) ? rs1_val
                                                           : rs2_val;
   wire [31:0] maxu_w = rs1_val < rs2_val ? rs2_val : rs1_val;
   wire [4:0]  rd_w   = instr[11:7];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_one_answer: assert property (op_valid |=>
      result_valid_ff != unsupported_ff) else $error("answer count wrong");
   a_idle_quiet: assert property (!op_valid |=>
      !result_valid_ff && !unsupported_ff) else $error("pulse without op");
   a_rd_capture: assert property (
      op_valid |=> rd_index_ff == $past(rd_w)) else $error("rd index wrong");
   a_abs_value: assert property (
      op_valid && reg_op && f7 == 7'h28 |=> result_ff == $past(abs_w))
      else $error("abs result wrong");
   a_sle_value: assert property (
      op_valid && reg_op && f7 == 7'h29 |=> result_ff == $past(sle_w))
      else $error("sle result wrong");
   a_min_value: assert property (
      op_valid && reg_op && f7 == 7'h2b |=> result_ff == $past(min_w))
      else $error("min result wrong");
   a_maxu_value: assert property (
      op_valid && reg_op && f7 == 7'h2e |=> result_ff == $past(maxu_w))
      else $error("maxu result wrong");
   a_acc_flag: assert property (
      op_valid && reg_op && f7[6:3] == 4'h8 |=> acc_op_ff && result_valid_ff)
      else $error("acc flag missing");
   a_unsup_hold: assert property (unsupported_ff |->
      result_ff == $past(result_ff)) else $error("result moved");
   c_acc: cover property (result_valid_ff && acc_op_ff);
   c_unsup: cover property (unsupported_ff);
   c_shimm: cover property (op_valid && instr[6:0] == 7'h5b);
endmodule
bind cga_general_alu cga_general_alu_asserts u_chk (.ref_clk(ref_clk),
   .rst(rst), .op_valid(op_valid), .instr(instr), .rs1_val(rs1_val),
   .rs2_val(rs2_val), .rd_val(rd_val), .result_ff(result_ff),
   .result_valid_ff(result_valid_ff), .rd_index_ff(rd_index_ff),
   .acc_op_ff(acc_op_ff), .unsupported_ff(unsupported_ff));

// ===== sim/cga_core_model.sv
// destination register of the core's writeback stage
// assumes one destination is tracked; bench preloads it
`timescale 1ns/10ps
module cga_core_model (
   input  wire logic        ref_clk,
   input  wire logic        load,
   input  wire logic [31:0] load_val,
   input  wire logic [31:0] result_ff,
   input  wire logic        result_valid_ff,
   input  wire logic        acc_op_ff,
   output logic      [31:0] rd_val_ff
);
   // writeback: accumulate results land in the destination
   always_ff @(posedge ref_clk) begin
      if (load) begin
         rd_val_ff <= load_val;
      end else if (result_valid_ff && acc_op_ff) begin
         rd_val_ff <= result_ff;
      end
   end
endmodule

// ===== sim/cga_general_alu_bench.sv
// self-checking bench for the general alu unit
// assumes one request every two cycles so writeback settles first
`timescale 1ns/10ps
module cga_general_alu_bench;
   logic        ref_clk = 0, rst = 1, op_valid = 0, load = 1;
   logic [31:0] instr = 0, rs1_val = 0, rs2_val = 0, load_val = 32'h1234;
   logic [31:0] rd_m = 32'h1234, held = 0, a, b;
   wire  [31:0] rd_val, result_ff;
   wire         result_valid_ff, acc_op_ff, unsupported_ff;
   wire  [4:0]  rd_index_ff;
   int          n_mismatch = 0, tests_run = 0, k;
   always #4 ref_clk = ~ref_clk;
   cga_general_alu dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid),
      .instr(instr), .rs1_val(rs1_val), .rs2_val(rs2_val), .rd_val(rd_val),
      .result_ff(result_ff), .result_valid_ff(result_valid_ff),
      .rd_index_ff(rd_index_ff), .acc_op_ff(acc_op_ff),
      .unsupported_ff(unsupported_ff));
   cga_core_model core (.ref_clk(ref_clk), .load(load), .load_val(load_val),
      .result_ff(result_ff), .result_valid_ff(result_valid_ff),
      .acc_op_ff(acc_op_ff), .rd_val_ff(rd_val));
   // ---------------------------------------------------------------
   // expectation and encoding helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] exp_val(input logic [31:0] i, a, b, d);
      logic [31:0] r, x, y;
      logic [4:0]  s;
      logic        sub, rnd, uns;
      longint      v, lo, hi, cb;
      int          w;
      v = longint'($signed(a));
      w = int'(i[24:20]);
      cb = longint'(b & 32'h7fffffff);
      hi = (w == 0) ? 0 : (longint'(1) << (w - 1)) - 1;
      lo = (w == 0) ? -1 : -(longint'(1) << (w - 1));
      if (i[6:0] == 7'h5b) begin
         {x, y, s, sub, rnd, uns} = {a, b, i[29:25], i[12], i[31], i[30]};
      end else begin
         {x, y, s, sub, rnd, uns} = {d, a, b[4:0], i[27], i[26], i[25]};
      end
      r = sub ? x - y : x + y;
      // no rounding term for a zero shift
      if (rnd && s != 0) r = r + (32'h1 << (s - 1));
      r = uns ? r >> s : $unsigned($signed(r) >>> s);
      if (i[6:0] == 7'h5b) return r;
      case (i[31:25])
         7'h28: return a[31] ? -a : a;
         7'h29: return {31'h0, $signed(a) <= $signed(b)};
         7'h2a: return {31'h0, a <= b};
         7'h2b: return $signed(a) < $signed(b) ? a : b;
         7'h2c: return a < b ? a : b;
         7'h2d: return $signed(a) < $signed(b) ? b : a;
         7'h2e: return a < b ? b : a;
         7'h30: return {{16{a[15]}}, a[15:0]};
         7'h31: return {16'h0, a[15:0]};
         7'h32: return {{24{a[7]}}, a[7:0]};
         7'h33: return {24'h0, a[7:0]};
         7'h38: return 32'(v <= lo ? lo : v >= hi ? hi : v);
         7'h39: return 32'(v <= 0 ? 0 : v >= hi ? hi : v);
         7'h3a: return 32'(v <= -cb - 1 ? -cb - 1 : v >= cb ? cb : v);
         7'h3b: return 32'(v <= 0 ? 0 : v >= cb ? cb : v);
         default: return r;
      endcase
   endfunction
   function automatic logic [31:0] rop(input logic [6:0] f,
                                       input logic [4:0] s2, rd);
      return {f, s2, 5'h1, 3'h3, rd, 7'h2b};
   endfunction
   function automatic logic [31:0] sop(input logic [1:0] f2,
                                       input logic [4:0] sh,
                                       input logic [2:0] f3);
      return {f2, sh, 5'h2, 5'h1, f3, 5'h3, 7'h5b};
   endfunction
   task automatic check_word(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one request, answer checked in the cycle after the taking edge
   task automatic issue(input logic [31:0] i, a, b);
      logic [31:0] e;
      logic        sup, acc;
      acc = i[6:0] == 7'h2b && i[14:12] == 3'h3 && i[31:28] == 4'h8;
      sup = acc || (i[6:0] == 7'h5b && i[14:13] == 2'b01) ||
            (i[6:0] == 7'h2b && i[14:12] == 3'h3 && (i[31:25] inside
            {[7'h28:7'h2e], [7'h30:7'h33], [7'h38:7'h3b]}));
      e = sup ? exp_val(i, a, b, rd_m) : held;
      @(posedge ref_clk);
      {op_valid, instr, rs1_val, rs2_val} <= {1'b1, i, a, b};
      @(posedge ref_clk);
      op_valid <= 0;
      #1;
      check_word("valid", 32'(sup), 32'(result_valid_ff));
      check_word("unsup", 32'(!sup), 32'(unsupported_ff));
      check_word("acc", 32'(acc), 32'(acc_op_ff));
      check_word("rd", 32'(i[11:7]), 32'(rd_index_ff));
      check_word("result", e, result_ff);
      held = e;
      if (acc) rd_m = e;
   endtask
   initial begin
      void'($urandom(37279));
      repeat (3) @(posedge ref_clk);
      {rst, load} <= 2'b00;
      @(posedge ref_clk);
      #1;
      check_word("reset", 32'h0, result_ff);
      issue(rop(7'h28, 0, 5), 32'h80000000, 0);
      issue(rop(7'h29, 0, 6), 32'hffffffff, 32'hffffffff);
      issue(rop(7'h2a, 0, 6), 32'hffffffff, 32'h1);
      issue(rop(7'h38, 0, 7), 32'h5, 0);
      issue(rop(7'h39, 0, 7), 32'h5, 0);
      issue(rop(7'h39, 5'h8, 7), 32'hffffff00, 0);
      issue(rop(7'h3a, 0, 8), 32'h80000000, 32'hffffffff);
      issue(sop(2'b10, 0, 3'h2), 32'h7fffffff, 1);
      issue(sop(2'b11, 5'h1f, 3'h3), 0, 1);
      issue(rop(7'h46, 0, 4), 32'h3, 32'h20);
      issue(rop(7'h20, 0, 2), 1, 2);
      // random mix over every decoded operation plus one foreign code
      repeat (1500) begin
         k = $urandom_range(0, 31);
         b = $urandom;
         a = ($urandom_range(0, 3) == 0) ? b : $urandom;
         if (k < 23) begin
            issue(rop(k < 7 ? 7'h28 + 7'(k) : k < 11 ? 7'h29 + 7'(k) :
                      k < 15 ? 7'h2d + 7'(k) : 7'h31 + 7'(k),
                      5'($urandom), 5'($urandom)), a, b);
         end else if (k < 31) begin
            issue(sop(2'(k), 5'($urandom), 3'h2 + 3'(k > 26)),
                  a, b);
         end else begin
            issue(rop(7'h24, 0, 5'($urandom)), a, b);
         end
      end
      finish_test();
   end
endmodule
